// ---- shared/spf_pkg.sv ----
// Package of register map and field constants for the serial status flags
package spf_pkg;

   // Data and address widths of the register bus
   localparam int SPF_DATA_W = 32;
   localparam int SPF_ADDR_W = 18;

   // Register indices; byte address is four times the index
   localparam logic [15:0] SPF_IDX_SERIAL_IO_STATUS = 16'hFFF6;
   localparam logic [15:0] SPF_IDX_CTRL = 16'hFFF8;
   localparam logic [15:0] SPF_IDX_DATA = 16'hFFF9;
   localparam logic [15:0] SPF_IDX_ISTAT = 16'hFFFA;
   localparam logic [15:0] SPF_IDX_IMASK = 16'hFFFB;

   localparam logic [17:0] SPF_ADDR_SERIAL_IO_STATUS = {SPF_IDX_SERIAL_IO_STATUS, 2'h0};
   localparam logic [17:0] SPF_ADDR_CTRL = {SPF_IDX_CTRL, 2'h0};
   localparam logic [17:0] SPF_ADDR_DATA = {SPF_IDX_DATA, 2'h0};
   localparam logic [17:0] SPF_ADDR_ISTAT = {SPF_IDX_ISTAT, 2'h0};
   localparam logic [17:0] SPF_ADDR_IMASK = {SPF_IDX_IMASK, 2'h0};

   // Status register fields
   localparam int SPF_SERIAL_IO_STATUS_RDY_BIT = 8;
   localparam int SPF_SERIAL_IO_STATUS_PIN3_BIT = 7;
   localparam int SPF_SERIAL_IO_STATUS_PIN2_BIT = 6;
   localparam int SPF_SERIAL_IO_STATUS_PIN1_BIT = 5;
   localparam int SPF_SERIAL_IO_STATUS_LVL3_BIT = 3;

   // Control register fields
   localparam int SPF_CTRL_EN_BIT = 0;
   localparam int SPF_CTRL_DIR3_BIT = 3;

   // Interrupt status and mask fields
   localparam int SPF_IRQ_RX_BIT = 0;
   localparam int SPF_IRQ_PIN3_BIT = 3;

   // Reset values
   localparam logic SPF_RST_EN = 1'h0;
   localparam logic [3:1] SPF_RST_DIR = 3'h0;
   localparam logic [3:0] SPF_RST_IMASK = 4'h0;

   // Cycles after reset before the pin synchroniser is filled
   localparam logic [1:0] SPF_SYNC_FILL = 2'h3;

endpackage

// ---- sim/spf_rx_partner.sv ----
// Remote transmitter and external pin model for the status flag bench
`timescale 1ns/1ns
module spf_rx_partner
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Commands from the bench
   input wire logic sendGo,
   input wire logic [7:0] sendChar,
   input wire logic [3:0] sendDelay,
   input wire logic [3:1] pinSet,
   // Receiver side and pins
   output logic rxCharStrobe,
   output logic [7:0] rxCharData,
   output logic [3:1] gpioPin
);
   logic busy;
   logic [3:0] waitCnt;
   logic [7:0] held;

   // Data toggles off the strobe so a stale byte is never mistaken for valid
   always_ff @(posedge sys_clk)
   begin
      rxCharStrobe <= 1'b0;
      gpioPin <= pinSet;
      waitCnt <= waitCnt - 4'h1;
      rxCharData <= ~rxCharData;
      if (!rst_n)
      begin
         busy <= 1'b0;
         rxCharData <= 8'h00;
      end
      else if (sendGo)
      begin
         busy <= 1'b1;
         waitCnt <= sendDelay;
         held <= sendChar;
      end
      else if (busy && waitCnt == 4'h0)
      begin
         busy <= 1'b0;
         rxCharStrobe <= 1'b1;
         rxCharData <= held;
      end
   end
endmodule

// ---- sim/spf_status_flags_bench.sv ----
// Self-checking bench for the serial port status flags
`timescale 1ns/1ns
module spf_status_flags_bench;
   logic sys_clk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic rxCharStrobe, portEnable, serialPortIrq, sendGo, rdErr;
   logic [7:0] rxCharData, sendChar;
   logic [3:0] sendDelay;
   logic [3:1] gpioPin, pinDirection, pinSet;
   logic [31:0] obs;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   spf_status_flags DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxCharStrobe(rxCharStrobe), .rxCharData(rxCharData),
      .gpioPin(gpioPin), .pinDirection(pinDirection),
      .portEnable(portEnable), .serialPortIrq(serialPortIrq));
   spf_rx_partner partner (.sys_clk(sys_clk), .rst_n(rst_n),
      .sendGo(sendGo), .sendChar(sendChar), .sendDelay(sendDelay),
      .pinSet(pinSet), .rxCharStrobe(rxCharStrobe),
      .rxCharData(rxCharData), .gpioPin(gpioPin));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk32(string nm, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Outputs are captured mid-cycle, away from the edge that updates them
   task automatic outs;
      @(negedge sys_clk);
      obs = {27'h0, serialPortIrq, portEnable, pinDirection};
      @(posedge sys_clk);
   endtask

   task automatic apb(logic wr, logic [17:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         num_errors++;
         end_sim;
      end
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rdc(string nm, logic [17:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk32(nm, exp, rdData);
   endtask

   task automatic waitIrq;
      for (int n = 0; n < 20 && serialPortIrq !== 1'b1; n++)
         @(negedge sys_clk);
      @(posedge sys_clk);
   endtask

   task automatic send(logic [7:0] c, logic [3:0] d);
      sendChar <= c;
      sendDelay <= d;
      sendGo <= 1'b1;
      @(posedge sys_clk);
      sendGo <= 1'b0;
      waitIrq;
   endtask

   task automatic setup;
      apb(1'b1, spf_pkg::SPF_ADDR_CTRL, 32'h1);
      apb(1'b1, spf_pkg::SPF_ADDR_IMASK, 32'hF);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         end_sim;
      end
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, sendGo} = 5'h00;
      {paddr, pwdata, sendChar, sendDelay, pinSet} = 65'h0;
      clkEn = 1'b1;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdc("status rst", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h0);
      rdc("ctrl rst", spf_pkg::SPF_ADDR_CTRL, 32'h0);
      rdc("mask rst", spf_pkg::SPF_ADDR_IMASK, 32'h0);
      outs;
      chk32("outs rst", 32'h0, obs);
      setup;
      $display("test reset done");
      for (int i = 0; i < 2; i++)
      begin
         send(i ? 8'h3C : 8'hA5, i ? 4'h9 : 4'h0);
         outs;
         chk32("rx irq", 32'h18, obs);
         rdc("ready set", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h100);
         rdc("rx data", spf_pkg::SPF_ADDR_DATA, i ? 32'h3C : 32'hA5);
         rdc("ready clear", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h0);
         apb(1'b1, spf_pkg::SPF_ADDR_ISTAT, 32'h1);
         outs;
         chk32("rx irq clear", 32'h08, obs);
      end
      send(8'h5A, 4'h2);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdc("ready reset", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h0);
      setup;
      $display("test receive done");
      for (int n = 1; n <= 3; n++)
      begin
         pinSet[n] <= 1'b1;
         waitIrq;
         outs;
         chk32("pin irq", 32'h18, obs);
         rdc("flag set", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h11 << n);
         apb(1'b1, spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h0);
         rdc("flag kept", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h11 << n);
         apb(1'b1, spf_pkg::SPF_ADDR_IMASK, 32'h0);
         outs;
         chk32("masked", 32'h08, obs);
         apb(1'b1, spf_pkg::SPF_ADDR_IMASK, 32'hF);
         pinSet[n] <= 1'b0;
         repeat (10) @(posedge sys_clk);
         rdc("flag sticky", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h10 << n);
         apb(1'b1, spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h10 << n);
         rdc("flag clear", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h0);
         apb(1'b1, spf_pkg::SPF_ADDR_ISTAT, 32'h1 << n);
         outs;
         chk32("irq clear", 32'h08, obs);
      end
      $display("test pins done");
      apb(1'b1, spf_pkg::SPF_ADDR_CTRL, 32'h9);
      pinSet <= 3'b100;
      repeat (10) @(posedge sys_clk);
      rdc("output pin", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h8);
      outs;
      chk32("dir out", 32'h0C, obs);
      pinSet <= 3'b000;
      apb(1'b1, spf_pkg::SPF_ADDR_CTRL, 32'h0);
      pinSet <= 3'b010;
      repeat (10) @(posedge sys_clk);
      rdc("disabled", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h4);
      apb(1'b1, spf_pkg::SPF_ADDR_CTRL, 32'h1);
      repeat (10) @(posedge sys_clk);
      rdc("change lost", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h4);
      outs;
      chk32("no irq", 32'h08, obs);
      $display("test refusal done");
      apb(1'b0, 18'h00100, 32'h0);
      chk32("bad read", 32'h0, rdData);
      chk32("bad read err", 32'h1, {31'h0, rdErr});
      apb(1'b1, 18'h00100, 32'hF);
      chk32("bad write err", 32'h1, {31'h0, rdErr});
      apb(1'b1, spf_pkg::SPF_ADDR_DATA, 32'hFF);
      rdc("data ro", spf_pkg::SPF_ADDR_DATA, 32'h0);
      $display("test unmapped done");
      clkEn <= 1'b0;
      send(8'h77, 4'h0);
      outs;
      chk32("frozen outs", 32'h08, obs);
      clkEn <= 1'b1;
      rdc("frozen strobe", spf_pkg::SPF_ADDR_SERIAL_IO_STATUS, 32'h4);
      $display("test freeze done");
      end_sim;
   end
endmodule

// ---- verilog/spf_pin_sync.sv ----
// Pin synchroniser and change detector for the general-purpose pins
`timescale 1ns/1ns
module spf_pin_sync
#(
   parameter int PINS = 3
)
(
   // Clock and control
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Pins in
   input wire logic [PINS-1:0] pinIn,
   // Synchronised results
   output logic [PINS-1:0] pinLevel,
   output logic [PINS-1:0] pinChange
);

   typedef struct packed
   {
      logic [PINS-1:0] meta;
      logic [PINS-1:0] sync;
      logic [PINS-1:0] last;
      logic [1:0] fill;
   } spf_sync_t;

   spf_sync_t st_reg;
   spf_sync_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.meta = pinIn;
      st_next.sync = st_reg.meta;
      st_next.last = st_reg.sync;
      if (st_reg.fill != spf_pkg::SPF_SYNC_FILL)
      begin
         st_next.fill = st_reg.fill + 2'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else if (clkEn)
      begin
         st_reg <= st_next;
      end
   end

   assign pinLevel = st_reg.sync;

   // Either edge counts; held off until the chain holds real samples
   genvar i;
   generate
      for (i = 0; i < PINS; i++)
      begin : g_chg
         assign pinChange[i] = (st_reg.fill == spf_pkg::SPF_SYNC_FILL) &&
            (st_reg.sync[i] != st_reg.last[i]);
      end
   endgenerate

endmodule

// ---- verilog/spf_status_flags.sv ----
// Serial port status flags with APB registers and interrupt
//
// Contract
// - Ready flag at bit 8 is set once a character sits in the data register.
// - Ready flag clears when the data register is read, and on reset.
// - Each newly received character raises the serial port interrupt.
// - Pin 3 change sets bit 7, only while pin 3 is input and port enabled.
// - Writing 1 to bit 7 clears the pin 3 flag; writing 0 keeps it.
// - A detected pin 3 change raises the serial port interrupt.
// - Pin 2 change sets bit 6, only while pin 2 is input and port enabled.
// - Writing 1 to bit 6 clears the pin 2 flag.
// - A detected pin 2 change raises the serial port interrupt.
// - Pin 1 change sets bit 5, only while pin 1 is input and port enabled.
// - Writing 1 to bit 5 clears the pin 1 flag.
// - A detected pin 1 change raises the serial port interrupt.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module spf_status_flags
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver side
   input wire logic rxCharStrobe,
   input wire logic [7:0] rxCharData,
   // General-purpose pins
   input wire logic [3:1] gpioPin,
   output logic [3:1] pinDirection,
   output logic portEnable,
   // Interrupt
   output logic serialPortIrq
);

   typedef struct packed
   {
      logic [7:0] holding;
      logic rxCharReadyFlag;
      logic [3:1] changeFlag;
      logic portEn;
      logic [3:1] dir;
      logic [3:0] irqStat;
      logic [3:0] irqMask;
      logic irq;
      logic ready;
      logic slvErr;
      logic [31:0] rdData;
   } spf_state_t;

   spf_state_t st_reg;
   spf_state_t st_next;

   logic [3:1] pinLevel;
   logic [3:1] pinChange;

   spf_pin_sync
   #(
      .PINS(3)
   )
   u_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .pinIn(gpioPin),
      .pinLevel(pinLevel),
      .pinChange(pinChange)
   );

   // Bus decode
   logic setupWait;
   logic accessDone;
   logic wrDone;
   logic rdDone;
   logic hitIosr;
   logic hitCtrl;
   logic hitData;
   logic hitIstat;
   logic hitImask;
   logic mapped;

   assign setupWait = psel && penable && !st_reg.ready;
   assign accessDone = psel && penable && st_reg.ready;
   assign wrDone = accessDone && pwrite;
   assign rdDone = accessDone && !pwrite;
   assign hitIosr = paddr == spf_pkg::SPF_ADDR_SERIAL_IO_STATUS;
   assign hitCtrl = paddr == spf_pkg::SPF_ADDR_CTRL;
   assign hitData = paddr == spf_pkg::SPF_ADDR_DATA;
   assign hitIstat = paddr == spf_pkg::SPF_ADDR_ISTAT;
   assign hitImask = paddr == spf_pkg::SPF_ADDR_IMASK;
   assign mapped = hitIosr || hitCtrl || hitData || hitIstat || hitImask;

   // Flag set and clear terms
   logic dataRead;
   logic [3:1] chgSet;
   logic [3:1] chgClr;
   logic [3:0] irqSet;
   logic [3:0] irqClr;

   assign dataRead = rdDone && hitData;

   // Change only counts on an input pin of an enabled port
   assign chgSet = pinChange & ~st_reg.dir & {3{st_reg.portEn}};

   assign chgClr = (wrDone && hitIosr) ?
      pwdata[spf_pkg::SPF_SERIAL_IO_STATUS_PIN3_BIT -: 3] : 3'h0;

   assign irqSet = {chgSet, rxCharStrobe};
   assign irqClr = (wrDone && hitIstat) ? pwdata[3:0] : 4'h0;

   // Read data
   logic [31:0] rdValue;

   always_comb
   begin
      rdValue = 32'h0;
      if (hitIosr)
      begin
         rdValue[spf_pkg::SPF_SERIAL_IO_STATUS_RDY_BIT] = st_reg.rxCharReadyFlag;
         rdValue[spf_pkg::SPF_SERIAL_IO_STATUS_PIN3_BIT -: 3] = st_reg.changeFlag;
         // Level bits show the synced pin whatever its direction
         rdValue[spf_pkg::SPF_SERIAL_IO_STATUS_LVL3_BIT -: 3] = pinLevel;
      end
      else if (hitCtrl)
      begin
         rdValue[spf_pkg::SPF_CTRL_EN_BIT] = st_reg.portEn;
         rdValue[spf_pkg::SPF_CTRL_DIR3_BIT -: 3] = st_reg.dir;
      end
      else if (hitData)
      begin
         rdValue[7:0] = st_reg.holding;
      end
      else if (hitIstat)
      begin
         rdValue[3:0] = st_reg.irqStat;
      end
      else if (hitImask)
      begin
         rdValue[3:0] = st_reg.irqMask;
      end
   end

   // Next state
   always_comb
   begin
      st_next = st_reg;

      // One wait state: answer is built from a stable address
      if (setupWait)
      begin
         st_next.ready = 1'b1;
         st_next.rdData = rdValue;
         st_next.slvErr = !mapped;
      end
      else if (accessDone)
      begin
         st_next.ready = 1'b0;
         st_next.slvErr = 1'b0;
      end

      if (wrDone && hitCtrl)
      begin
         st_next.portEn = pwdata[spf_pkg::SPF_CTRL_EN_BIT];
         st_next.dir = pwdata[spf_pkg::SPF_CTRL_DIR3_BIT -: 3];
      end
      if (wrDone && hitImask)
      begin
         st_next.irqMask = pwdata[3:0];
      end

      // A data read clears the ready flag; a new character in the same cycle wins
      if (dataRead)
      begin
         st_next.rxCharReadyFlag = 1'b0;
      end
      if (rxCharStrobe)
      begin
         st_next.holding = rxCharData;
         st_next.rxCharReadyFlag = 1'b1;
      end

      // Sticky flags; set beats clear
      st_next.changeFlag = (st_reg.changeFlag & ~chgClr) | chgSet;
      st_next.irqStat = (st_reg.irqStat & ~irqClr) | irqSet;

      st_next.irq = |(st_next.irqStat & st_next.irqMask);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.portEn <= spf_pkg::SPF_RST_EN;
         st_reg.dir <= spf_pkg::SPF_RST_DIR;
         st_reg.irqMask <= spf_pkg::SPF_RST_IMASK;
      end
      else if (clkEn)
      begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdData;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slvErr;
   assign pinDirection = st_reg.dir;
   assign portEnable = st_reg.portEn;
   assign serialPortIrq = st_reg.irq;

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   rdy_set_a: assert property (
      clkEn && rxCharStrobe |=> st_reg.rxCharReadyFlag &&
         st_reg.holding == $past(rxCharData))
      else $error("ready flag not set on new character");

   rdy_clear_a: assert property (
      clkEn && dataRead && !rxCharStrobe |=> !st_reg.rxCharReadyFlag)
      else $error("ready flag not cleared by data read");

   rx_irq_a: assert property (
      clkEn && rxCharStrobe && st_reg.irqMask[spf_pkg::SPF_IRQ_RX_BIT]
         |=> serialPortIrq && st_reg.irqStat[spf_pkg::SPF_IRQ_RX_BIT])
      else $error("no interrupt on received character");

   pin3_set_a: assert property (
      clkEn && pinChange[3] && !st_reg.dir[3] && st_reg.portEn
         |=> st_reg.changeFlag[3])
      else $error("pin 3 change not flagged");

   pin3_clear_a: assert property (
      clkEn && chgClr[3] && !chgSet[3] |=> !st_reg.changeFlag[3])
      else $error("pin 3 flag not cleared by write of one");

   pin3_irq_a: assert property (
      clkEn && chgSet[3] && st_reg.irqMask[spf_pkg::SPF_IRQ_PIN3_BIT]
         |=> serialPortIrq)
      else $error("no interrupt on pin 3 change");

   pin2_gate_a: assert property (
      clkEn && !st_reg.changeFlag[2] && (st_reg.dir[2] || !st_reg.portEn)
         |=> !st_reg.changeFlag[2])
      else $error("pin 2 flag set while not allowed");

   pin2_clear_a: assert property (
      clkEn && wrDone && hitIosr && pwdata[spf_pkg::SPF_SERIAL_IO_STATUS_PIN2_BIT] &&
         !chgSet[2] |=> !st_reg.changeFlag[2])
      else $error("pin 2 flag not cleared");

   pin2_irq_a: assert property (
      clkEn && chgSet[2] && st_reg.irqMask[2] |=> serialPortIrq)
      else $error("no interrupt on pin 2 change");

   pin1_set_a: assert property (
      clkEn && pinChange[1] && !st_reg.dir[1] && st_reg.portEn
         |=> st_reg.changeFlag[1] && st_reg.irqStat[1])
      else $error("pin 1 change not flagged");

   pin1_clear_a: assert property (
      clkEn && chgClr[1] && !chgSet[1] |=> !st_reg.changeFlag[1])
      else $error("pin 1 flag not cleared");

   pin1_irq_a: assert property (
      clkEn && chgSet[1] && st_reg.irqMask[1] |=> serialPortIrq)
      else $error("no interrupt on pin 1 change");

   flag_sticky_a: assert property (
      clkEn && st_reg.changeFlag[3] && !chgClr[3]
         |=> st_reg.changeFlag[3])
      else $error("pin 3 flag dropped without a clear");

   freeze_hold_a: assert property (
      !clkEn |=> $stable(st_reg))
      else $error("state moved while clock enable low");

   apb_wait_a: assert property (
      clkEn && setupWait |=> pready && prdata == $past(rdValue) ##1
         (!pready || !$past(clkEn)))
      else $error("bus answer timing wrong");

   pin3_gate_a: assert property (
      clkEn && !st_reg.changeFlag[3] && (st_reg.dir[3] || !st_reg.portEn)
         |=> !st_reg.changeFlag[3])
      else $error("pin 3 flag set while not allowed");

   pin2_set_a: assert property (
      clkEn && pinChange[2] && !st_reg.dir[2] && st_reg.portEn
         |=> st_reg.changeFlag[2])
      else $error("pin 2 change not flagged");

   pin1_gate_a: assert property (
      clkEn && !st_reg.changeFlag[1] && (st_reg.dir[1] || !st_reg.portEn)
         |=> !st_reg.changeFlag[1])
      else $error("pin 1 flag set while not allowed");

   pin2_sticky_a: assert property (
      clkEn && st_reg.changeFlag[2] && !chgClr[2]
         |=> st_reg.changeFlag[2])
      else $error("pin 2 flag dropped without a clear");

   pin1_sticky_a: assert property (
      clkEn && st_reg.changeFlag[1] && !chgClr[1]
         |=> st_reg.changeFlag[1])
      else $error("pin 1 flag dropped without a clear");

   rdy_hold_a: assert property (
      clkEn && st_reg.rxCharReadyFlag && !dataRead
         |=> st_reg.rxCharReadyFlag)
      else $error("ready flag dropped without a data read");

   rx_stat_a: assert property (
      clkEn && rxCharStrobe
         |=> st_reg.irqStat[spf_pkg::SPF_IRQ_RX_BIT])
      else $error("rx interrupt status not set");

   // Software cannot forge a received character
   data_ro_a: assert property (
      clkEn && wrDone && hitData && !rxCharStrobe
         |=> $stable(st_reg.holding))
      else $error("data register changed by a write");

   bad_addr_a: assert property (
      clkEn && setupWait && !mapped
         |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");

   // Interrupt status is independent of the change flags
   rx_stat_clear_a: assert property (
      clkEn && irqClr[spf_pkg::SPF_IRQ_RX_BIT] && !rxCharStrobe
         |=> !st_reg.irqStat[spf_pkg::SPF_IRQ_RX_BIT])
      else $error("rx interrupt status not cleared");

endmodule
